/* hw/fsc_pkg.sv */
// Shared constants, types and register map of the flash sequencer controller.
// Assumes a 200 MHz core clock and a parallel NOR flash used in 16-bit word mode.
package fsc_pkg;

    // Clock period and the flash timing figures, each in its own unit.
    localparam int unsigned CLK_PERIOD_PS = 5000;        // Core clock period.
    localparam int unsigned CLK_HZ        = 200_000_000; // Core clock rate.
    localparam int unsigned T_AS_NS       = 10;          // Address set-up before a strobe.
    localparam int unsigned T_WP_NS       = 100;         // Write pulse width.
    localparam int unsigned T_WPH_NS      = 50;          // Write pulse width high.
    localparam int unsigned T_ACC_NS      = 120;         // Address to output delay.
    localparam int unsigned T_RDH_NS      = 150;         // Read strobe high pulse.
    localparam int unsigned ERASE_MAX_S   = 10;          // Longest erase cycle.

    // Least times round up to whole core clock cycles.
    localparam logic [7:0] AS_CYC   = 8'((T_AS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] WP_CYC   = 8'((T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] WPH_CYC  = 8'((T_WPH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] ACC_CYC  = 8'((T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [7:0] RDH_CYC  = 8'((T_RDH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam longint unsigned ERASE_TIMEOUT_CYC = longint'(ERASE_MAX_S) * longint'(CLK_HZ);

    // Flash bus widths.
    localparam int unsigned ADDR_W = 19; // Word address lines.
    localparam int unsigned DATA_W = 16; // Data lines.

    // Command addresses and command bytes written to the flash.
    localparam logic [15:0] CMD_ADDR_A      = 16'h5555; // First unlock address.
    localparam logic [15:0] CMD_ADDR_B      = 16'h2aaa; // Second unlock address.
    localparam logic [15:0] CHIP_ERASE_ADDR = CMD_ADDR_A;
    localparam logic [7:0]  CMD_UNLOCK_A    = 8'haa;
    localparam logic [7:0]  CMD_UNLOCK_B    = 8'h55;
    localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
    localparam logic [7:0]  CMD_SECT_ERASE  = 8'h30;
    localparam logic [7:0]  CMD_PROGRAM     = 8'ha0;
    localparam logic [7:0]  CMD_ID_ENTRY    = 8'h90;
    localparam logic [7:0]  CMD_ID_EXIT     = 8'hf0;
    localparam logic [7:0]  CMD_LOCKOUT     = 8'h40;
    localparam int unsigned STATUS_TOGGLE_LINE = 6; // Data line that toggles while busy.

    // Avalon byte offsets of the controller registers.
    localparam logic [4:0] REG_CTRL    = 5'h00;
    localparam logic [4:0] REG_ADDR    = 5'h04;
    localparam logic [4:0] REG_WDATA   = 5'h08;
    localparam logic [4:0] REG_RDATA   = 5'h0c;
    localparam logic [4:0] REG_STATUS  = 5'h10;
    localparam logic [4:0] REG_IRQ_ST  = 5'h14;
    localparam logic [4:0] REG_IRQ_CLR = 5'h18;
    localparam logic [4:0] REG_IRQ_EN  = 5'h1c;

    // Field positions.
    localparam int unsigned CTRL_START_BIT = 8; // Start strobe in the control register.
    localparam int unsigned ST_BUSY_BIT    = 0;
    localparam int unsigned ST_ID_BIT      = 1;
    localparam int unsigned ST_LOCK_BIT    = 2;
    localparam int unsigned ST_TMO_BIT     = 3;
    localparam int unsigned IRQ_DONE_BIT   = 0;
    localparam int unsigned IRQ_TMO_BIT    = 1;

    // Operations that software may start.
    typedef enum logic [2:0] {
        OP_READ       = 3'b000,
        OP_PROGRAM    = 3'b001,
        OP_CHIP_ERASE = 3'b010,
        OP_SECT_ERASE = 3'b011,
        OP_ID_ENTER   = 3'b100,
        OP_ID_EXIT    = 3'b101,
        OP_ID_EXIT1   = 3'b110,
        OP_LOCKOUT    = 3'b111
    } fsc_op_type;

    // Flash pins driven by the controller.
    typedef struct packed {
        logic              ce_n;   // Chip enable, active low.
        logic              oe_n;   // Output enable, active low.
        logic              we_n;   // Write enable, active low.
        logic [ADDR_W-1:0] addr;   // Word address.
        logic [DATA_W-1:0] dq_out; // Data driven onto the flash.
        logic              dq_oe;  // High while the controller drives data.
    } fsc_pins_type;

    // One flash write: address and data.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fsc_wr_type;

endpackage : fsc_pkg

/* hw/fsc_bus_cycle.sv */
// One flash bus cycle, write or read, timed in core clock cycles.
// Assumes dq_in is synchronous to core_clk and start comes only while idle.
module fsc_bus_cycle
    import fsc_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  start,
    input  wire logic                  is_write,
    input  wire logic [ADDR_W-1:0]     addr,
    input  wire logic [DATA_W-1:0]     wdata,
    input  wire logic [DATA_W-1:0]     dq_in,
    output logic                       done,
    output logic      [DATA_W-1:0]     rdata,
    output fsc_pkg::fsc_pins_type      pins
);
    import fsc_pkg::*;

    // Phases of one cycle.
    typedef enum logic [1:0] {
        CY_IDLE  = 2'b00,
        CY_SETUP = 2'b01,
        CY_PULSE = 2'b10,
        CY_RECOV = 2'b11
    } fsc_cy_type;

    // Whole state of the cycle engine.
    typedef struct packed {
        fsc_cy_type        st;    // Current phase.
        logic [7:0]        cnt;   // Cycles left in the phase.
        logic              wr;    // Cycle is a write.
        logic              done;  // One-cycle completion pulse.
        logic [DATA_W-1:0] rdata; // Data captured by the last read.
        fsc_pins_type      pins;  // Pin levels.
    } fsc_cy_state_type;

    fsc_cy_state_type s_q; // Registered state.
    fsc_cy_state_type s_d; // Next state.

    // Next-state logic of the cycle engine.
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        unique case (s_q.st)
            CY_IDLE: begin
                // Address and data settle with only chip enable low.
                if (start) begin
                    s_d.pins.addr   = addr;
                    s_d.pins.dq_out = wdata;
                    s_d.pins.dq_oe  = is_write;
                    s_d.pins.ce_n   = 1'b0;
                    s_d.pins.oe_n   = 1'b1;
                    s_d.pins.we_n   = 1'b1;
                    s_d.wr          = is_write;
                    s_d.cnt         = AS_CYC - 8'h01;
                    s_d.st          = CY_SETUP;
                end
            end
            CY_SETUP: begin
                // Open the write pulse or the read strobe.
                if (s_q.cnt == 8'h00) begin
                    if (s_q.wr) begin
                        s_d.pins.we_n = 1'b0;
                        s_d.cnt       = WP_CYC - 8'h01;
                    end else begin
                        s_d.pins.oe_n = 1'b0;
                        s_d.cnt       = ACC_CYC - 8'h01;
                    end
                    s_d.st = CY_PULSE;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            CY_PULSE: begin
                // Close the strobe and raise chip enable; a read also samples data.
                if (s_q.cnt == 8'h00) begin
                    if (s_q.wr) begin
                        s_d.pins.we_n = 1'b1;
                        s_d.cnt       = WPH_CYC - 8'h01;
                    end else begin
                        s_d.rdata     = dq_in;
                        s_d.pins.oe_n = 1'b1;
                        s_d.cnt       = RDH_CYC - 8'h01;
                    end
                    s_d.pins.ce_n = 1'b1;
                    s_d.st        = CY_RECOV;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
            CY_RECOV: begin
                // Write data stays driven here as hold time; strobes stay high.
                if (s_q.cnt == 8'h00) begin
                    s_d.pins.dq_oe = 1'b0;
                    s_d.done       = 1'b1;
                    s_d.st         = CY_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 8'h01;
                end
            end
        endcase
    end

    // State register; every strobe idles high.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q      <= '0;
            s_q.st   <= CY_IDLE;
            s_q.pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign done  = s_q.done;
    assign rdata = s_q.rdata;
    assign pins  = s_q.pins;

endmodule : fsc_bus_cycle

/* hw/fsc_ctrl.sv */
// Host-side controller of a parallel NOR flash: command sequences, toggle polling,
// identification mode and boot-block lockout, ordered over Avalon-MM registers.
// Assumes the flash runs in word mode and the pin inputs are synchronous to core_clk.
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
module fsc_ctrl
    import fsc_pkg::*;
#(
    parameter logic [31:0] POLL_TIMEOUT_CYC = 32'(fsc_pkg::ERASE_TIMEOUT_CYC)
)
(
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic [4:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    output logic                       irq,
    input  wire logic [15:0]           dq_in,
    output fsc_pkg::fsc_pins_type      flash_pins
);
    import fsc_pkg::*;

    // Controller phases.
    typedef enum logic [1:0] {
        M_IDLE  = 2'b00,
        M_ISSUE = 2'b01,
        M_WAIT  = 2'b10
    } fsc_mst_type;

    // Whole state of the controller.
    typedef struct packed {
        fsc_mst_type       st;       // Current phase.
        fsc_op_type        op;       // Operation in progress.
        logic [2:0]        step;     // Write index within the command sequence.
        logic              polling;  // Toggle polling in progress.
        logic              have_prv; // A previous poll value is held.
        logic              prv_tog;  // Toggle line at the previous poll.
        logic [31:0]       poll_cnt; // Cycles spent polling.
        logic              cyc_go;   // Start pulse to the cycle engine.
        logic              cyc_wr;   // Cycle direction.
        fsc_wr_type        cyc;      // Cycle address and data.
        logic [ADDR_W-1:0] addr;     // Target address from software.
        logic [DATA_W-1:0] wdata;    // Program data from software.
        logic [DATA_W-1:0] rdata;    // Last array or identification read result.
        logic              id_mode;  // Identification mode believed active.
        logic              lock_set; // Lockout sequence has been written.
        logic              tmo;      // Last poll ended by timeout.
        logic [1:0]        irq_st;   // Sticky event bits.
        logic [1:0]        irq_en;   // Event enables.
        logic              irq;      // Interrupt level.
        logic              wait_rq;  // Waitrequest level, low in the answer cycle.
        logic [31:0]       rd;       // Bus read data.
    } fsc_ctl_state_type;

    fsc_ctl_state_type s_q;     // Registered state.
    fsc_ctl_state_type s_d;     // Next state.
    logic              cy_done; // Cycle engine finished.
    logic [15:0]       cy_rd;   // Data read by the cycle engine.

    // Builds a command write: upper address and upper data lines stay zero.
    function automatic fsc_wr_type cmd(input logic [15:0] a, input logic [7:0] d);
        cmd.addr = {3'h0, a};
        cmd.data = {8'h00, d};
    endfunction : cmd

    // Index of the last write in the sequence of an operation.
    function automatic logic [2:0] seq_last(input fsc_op_type op);
        unique case (op)
            OP_PROGRAM:                              seq_last = 3'd3;
            OP_CHIP_ERASE, OP_SECT_ERASE, OP_LOCKOUT: seq_last = 3'd5;
            OP_ID_ENTER, OP_ID_EXIT:                 seq_last = 3'd2;
            OP_READ, OP_ID_EXIT1:                    seq_last = 3'd0;
        endcase
    endfunction : seq_last

    // Address and data of one write of a command sequence.
    function automatic fsc_wr_type seq_word(input fsc_op_type op, input logic [2:0] step,
                                            input logic [ADDR_W-1:0] a,
                                            input logic [DATA_W-1:0] d);
        seq_word = cmd(CMD_ADDR_A, CMD_UNLOCK_A);
        if (op == OP_ID_EXIT1) begin
            seq_word = cmd(CMD_ADDR_A, CMD_ID_EXIT);
        end else begin
            unique case (step)
                3'd1: seq_word = cmd(CMD_ADDR_B, CMD_UNLOCK_B);
                3'd2: begin
                    unique case (op)
                        OP_PROGRAM:  seq_word = cmd(CMD_ADDR_A, CMD_PROGRAM);
                        OP_ID_ENTER: seq_word = cmd(CMD_ADDR_A, CMD_ID_ENTRY);
                        OP_ID_EXIT:  seq_word = cmd(CMD_ADDR_A, CMD_ID_EXIT);
                        default:     seq_word = cmd(CMD_ADDR_A, CMD_ERASE_SETUP);
                    endcase
                end
                3'd3: begin
                    if (op == OP_PROGRAM) begin
                        seq_word = '{addr: a, data: d};
                    end
                end
                3'd4: seq_word = cmd(CMD_ADDR_B, CMD_UNLOCK_B);
                3'd5: begin
                    unique case (op)
                        OP_CHIP_ERASE: seq_word = cmd(CHIP_ERASE_ADDR, CMD_CHIP_ERASE);
                        OP_SECT_ERASE: seq_word = '{addr: a, data: {8'h00, CMD_SECT_ERASE}};
                        default:       seq_word = cmd(CMD_ADDR_A, CMD_LOCKOUT);
                    endcase
                end
                default: seq_word = cmd(CMD_ADDR_A, CMD_UNLOCK_A);
            endcase
        end
    endfunction : seq_word

    // Next-state logic: bus slave, sequencing, polling and interrupts.
    always_comb begin
        s_d        = s_q;
        s_d.cyc_go = 1'b0;

        // Bus slave: answer one cycle after the request, commit at the answer edge.
        if (s_q.wait_rq && (avs_read || avs_write)) begin
            s_d.wait_rq = 1'b0;
            unique case (avs_address)
                REG_CTRL:   s_d.rd = {29'h0, s_q.op};
                REG_ADDR:   s_d.rd = {13'h0, s_q.addr};
                REG_WDATA:  s_d.rd = {16'h0, s_q.wdata};
                REG_RDATA:  s_d.rd = {16'h0, s_q.rdata};
                REG_STATUS: s_d.rd = {28'h0, s_q.tmo, s_q.lock_set, s_q.id_mode,
                                      s_q.st != M_IDLE};
                REG_IRQ_ST: s_d.rd = {30'h0, s_q.irq_st};
                REG_IRQ_EN: s_d.rd = {30'h0, s_q.irq_en};
                default:    s_d.rd = 32'h0000_0000;
            endcase
        end else if (!s_q.wait_rq) begin
            s_d.wait_rq = 1'b1;
            if (avs_write && (avs_byteenable != 4'h0)) begin
                unique case (avs_address)
                    REG_CTRL: begin
                        // A start while busy is ignored.
                        if (avs_writedata[CTRL_START_BIT] && s_q.st == M_IDLE) begin
                            s_d.op       = fsc_op_type'(avs_writedata[2:0]);
                            s_d.step     = 3'd0;
                            s_d.polling  = 1'b0;
                            s_d.st       = M_ISSUE;
                            s_d.cyc_wr   = fsc_op_type'(avs_writedata[2:0]) != OP_READ;
                            s_d.cyc      = (fsc_op_type'(avs_writedata[2:0]) == OP_READ)
                                         ? fsc_wr_type'{addr: s_q.addr, data: s_q.wdata}
                                         : seq_word(fsc_op_type'(avs_writedata[2:0]), 3'd0,
                                                    s_q.addr, s_q.wdata);
                        end
                    end
                    REG_ADDR:    s_d.addr   = avs_writedata[ADDR_W-1:0];
                    REG_WDATA:   s_d.wdata  = avs_writedata[DATA_W-1:0];
                    REG_IRQ_CLR: s_d.irq_st = s_q.irq_st & ~avs_writedata[1:0];
                    REG_IRQ_EN:  s_d.irq_en = avs_writedata[1:0];
                    default: begin
                        // Unmapped and read-only offsets ignore writes.
                    end
                endcase
            end
        end

        // Sequencer.
        unique case (s_q.st)
            M_IDLE: begin
                // Waiting for a start from software.
            end
            M_ISSUE: begin
                // One start pulse to the cycle engine.
                s_d.cyc_go = 1'b1;
                s_d.st     = M_WAIT;
            end
            M_WAIT: begin
                if (s_q.polling) begin
                    s_d.poll_cnt = s_q.poll_cnt + 32'h1;
                end
                if (cy_done) begin
                    if (s_q.polling) begin
                        // Completion is two successive reads with equal toggle line.
                        if (s_q.have_prv && cy_rd[STATUS_TOGGLE_LINE] == s_q.prv_tog) begin
                            s_d.st                   = M_IDLE;
                            s_d.irq_st[IRQ_DONE_BIT] = 1'b1;
                        end else if (s_q.poll_cnt >= POLL_TIMEOUT_CYC) begin
                            s_d.st                  = M_IDLE;
                            s_d.tmo                 = 1'b1;
                            s_d.irq_st[IRQ_TMO_BIT] = 1'b1;
                        end else begin
                            s_d.prv_tog  = cy_rd[STATUS_TOGGLE_LINE];
                            s_d.have_prv = 1'b1;
                            s_d.st       = M_ISSUE;
                        end
                    end else if (!s_q.cyc_wr) begin
                        // Single array or identification read.
                        s_d.rdata                = cy_rd;
                        s_d.st                   = M_IDLE;
                        s_d.irq_st[IRQ_DONE_BIT] = 1'b1;
                    end else if (s_q.step != seq_last(s_q.op)) begin
                        s_d.step = s_q.step + 3'd1;
                        s_d.cyc  = seq_word(s_q.op, s_q.step + 3'd1, s_q.addr, s_q.wdata);
                        s_d.st   = M_ISSUE;
                    end else if (s_q.op inside {OP_PROGRAM, OP_CHIP_ERASE, OP_SECT_ERASE}) begin
                        // Poll reads reuse the final write address unchanged.
                        s_d.polling  = 1'b1;
                        s_d.have_prv = 1'b0;
                        s_d.poll_cnt = 32'h0;
                        s_d.tmo      = 1'b0;
                        s_d.cyc_wr   = 1'b0;
                        s_d.st       = M_ISSUE;
                    end else begin
                        // Mode-changing sequences end without polling.
                        if (s_q.op == OP_ID_ENTER) begin
                            s_d.id_mode = 1'b1;
                        end
                        if (s_q.op inside {OP_ID_EXIT, OP_ID_EXIT1}) begin
                            s_d.id_mode = 1'b0;
                        end
                        if (s_q.op == OP_LOCKOUT) begin
                            s_d.lock_set = 1'b1;
                        end
                        s_d.st                   = M_IDLE;
                        s_d.irq_st[IRQ_DONE_BIT] = 1'b1;
                    end
                end
            end
            default: s_d.st = M_IDLE;
        endcase

        // Interrupt level follows the enabled sticky bits.
        s_d.irq = |(s_d.irq_st & s_d.irq_en);
    end

    // State register.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q         <= '0;
            s_q.st      <= M_IDLE;
            s_q.wait_rq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Cycle engine that times each flash strobe.
    fsc_bus_cycle u_cycle (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .start    (s_q.cyc_go),
        .is_write (s_q.cyc_wr),
        .addr     (s_q.cyc.addr),
        .wdata    (s_q.cyc.data),
        .dq_in    (dq_in),
        .done     (cy_done),
        .rdata    (cy_rd),
        .pins     (flash_pins)
    );

    assign avs_readdata    = s_q.rd;
    assign avs_waitrequest = s_q.wait_rq;
    assign irq             = s_q.irq;

endmodule : fsc_ctrl

/* testbench/fsc_ctrl_asserts.sv */
// Checker of the flash strobes and the register bus handshake.
// Assumes it is bound to fsc_ctrl and sees only its ports.
module fsc_ctrl_asserts
    import fsc_pkg::*;
(
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  avs_waitrequest,
    input  wire fsc_pkg::fsc_pins_type flash_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // A write begins when the write strobe falls under chip enable.
    sequence s_wr; $fell(flash_pins.we_n) ##0 !flash_pins.ce_n; endsequence
    property p_oe_off; !flash_pins.we_n |-> flash_pins.oe_n; endproperty
    a_oe_off: assert property (p_oe_off) else $error("oe low in write");
    property p_wp; s_wr |-> !flash_pins.we_n [*8]; endproperty
    a_wp: assert property (p_wp) else $error("write pulse short");
    property p_chip; s_wr ##0 flash_pins.dq_out == 16'h0010 |-> flash_pins.addr == 19'h05555;
    endproperty
    a_chip: assert property (p_chip) else $error("chip erase address");
    property p_rdcs; $fell(flash_pins.oe_n) |-> !flash_pins.ce_n && !flash_pins.dq_oe; endproperty
    a_rdcs: assert property (p_rdcs) else $error("read strobe bad");
    property p_hold; !flash_pins.oe_n && !$fell(flash_pins.oe_n) |-> $stable(flash_pins.addr);
    endproperty
    a_hold: assert property (p_hold) else $error("read address moved");
    property p_hib; s_wr ##0 flash_pins.addr == 19'h05555 |-> flash_pins.dq_out[15:8] == 8'h00;
    endproperty
    a_hib: assert property (p_hib) else $error("command high byte");
    property p_wait; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("answer too long");
endmodule : fsc_ctrl_asserts
bind fsc_ctrl fsc_ctrl_asserts u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .avs_waitrequest(avs_waitrequest), .flash_pins(flash_pins));

/* testbench/fsc_flash_model.sv */
// Behavioural flash that decodes command writes and answers reads.
// Assumes pins change on core_clk; released data lines show the inverse.
module fsc_flash_model
    import fsc_pkg::*;
#(
    parameter logic [15:0] MAKER = 16'h5a01, // Arbitrary value.
    parameter logic [15:0] PART  = 16'h5a02  // Arbitrary value.
)
(
    input  wire logic                  core_clk,
    input  wire fsc_pkg::fsc_pins_type pins,
    input  wire logic [7:0]            busy_len,
    output logic      [15:0]           dq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0;
    logic [23:0] h = 24'h0;
    logic [7:0]  bz = 8'h0;
    logic        id = 1'b0; // Powers up out of identification mode.
    logic        lk = 1'b0, t = 1'b0, pw = 1'b1, pr = 1'b1;
    wire         rd = !pins.ce_n && !pins.oe_n;
    wire  [7:0]  c = pins.dq_out[7:0];
    // Busy status, identification codes or array data while read.
    assign dq = !rd ? ~last : bz != 8'h0 ? {9'h0, t, 6'h0}
              : id ? (pins.addr[0] ? PART : MAKER) : mem[pins.addr[3:0]];
    // Commands take effect as the write strobe rises.
    always @(posedge core_clk) begin
        pw <= pins.we_n;
        pr <= !rd;
        if (rd) last <= dq;
        if (!pr && !rd && bz != 8'h0) begin
            t <= !t;
            bz <= bz - 8'h1;
        end
        if (!pw && pins.we_n) begin
            h <= {h[15:0], c};
            if (h == 24'haa55a0 && !(lk && pins.addr < 19'h02000)) begin
                mem[pins.addr[3:0]] <= pins.dq_out;
                bz <= busy_len;
            end
            if (h[15:0] == 16'haa55 && c == 8'h90) id <= 1'b1;
            if (c == 8'hf0) id <= 1'b0;
            if (h == 24'h80aa55 && c == 8'h40) lk <= 1'b1;
            if (h == 24'h80aa55 && (c == 8'h10 || c == 8'h30)) begin
                foreach (mem[i]) mem[i] <= 16'hffff;
                bz <= busy_len;
            end
        end
    end
endmodule : fsc_flash_model

/* testbench/test_fsc_ctrl.sv */
// Self-checking bench of the flash controller against the flash model.
// Assumes a shortened poll timeout so that the timeout case stays brief.
module test_fsc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import fsc_pkg::*;
    typedef struct {fsc_op_type o; logic [18:0] a; logic [15:0] d, e; bit c;} fsc_row_type;
    logic core_clk = 0, sys_rst = 1, rd = 0, wr = 0, irq, wq;
    logic [4:0] adr = 0;
    logic [31:0] wd = 0, q, rq;
    logic [15:0] dq;
    logic [7:0] bl = 3;
    fsc_pins_type pins;
    int n_fail = 0, n_tests = 0;
    fsc_row_type rows[] = '{'{OP_CHIP_ERASE, 19'h05555, 0, 0, 0},
        '{OP_PROGRAM, 19'h40003, 16'h1234, 0, 0}, '{OP_READ, 19'h40003, 0, 16'h1234, 1},
        '{OP_ID_ENTER, 0, 0, 0, 0}, '{OP_READ, 0, 0, 16'h5a01, 1},
        '{OP_READ, 1, 0, 16'h5a02, 1}, '{OP_ID_EXIT, 0, 0, 0, 0},
        '{OP_READ, 19'h40003, 0, 16'h1234, 1}, '{OP_ID_ENTER, 0, 0, 0, 0},
        '{OP_ID_EXIT1, 0, 0, 0, 0}, '{OP_READ, 19'h40003, 0, 16'h1234, 1},
        '{OP_SECT_ERASE, 19'h40003, 0, 0, 0}, '{OP_READ, 19'h40003, 0, 16'hffff, 1},
        '{OP_LOCKOUT, 0, 0, 0, 0}, '{OP_PROGRAM, 19'h00005, 16'h0777, 0, 0},
        '{OP_READ, 19'h00005, 0, 16'hffff, 1}, '{OP_PROGRAM, 19'h40005, 16'h0abc, 0, 0},
        '{OP_READ, 19'h40005, 0, 16'h0abc, 1}};
    fsc_ctrl #(.POLL_TIMEOUT_CYC(32'd2000)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
        .avs_byteenable(4'hf), .avs_readdata(q), .avs_waitrequest(wq), .irq(irq),
        .dq_in(dq), .flash_pins(pins));
    fsc_flash_model u_fl (.core_clk(core_clk), .pins(pins), .busy_len(bl), .dq(dq));
    initial forever #2.5 core_clk = ~core_clk;
    // Watchdog over the whole run.
    initial begin
        #500000;
        n_fail++;
        give_verdict();
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    // One Avalon access, held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge core_clk); while (wq !== 1'b0);
        rq = q;
        wr <= 0;
        rd <= 0;
    endtask : bus
    // Starts one operation, waits while busy, then fetches the read data.
    task automatic op(input fsc_op_type o, input logic [18:0] a, input logic [15:0] d);
        bus(1, REG_ADDR, 32'(a));
        bus(1, REG_WDATA, 32'(d));
        bus(1, REG_CTRL, 32'h100 | 32'(o));
        do bus(0, REG_STATUS, 0); while (rq[0] !== 1'b0);
        bus(0, REG_RDATA, 0);
    endtask : op
    task automatic give_verdict;
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // Reset, table of operations, then interrupts, lockout, unmapped and timeout cases.
    initial begin
        repeat (6) @(posedge core_clk);
        chk(32'({wq, irq, pins.ce_n, pins.we_n, pins.dq_oe}), 32'h16);
        repeat (6) @(posedge core_clk);
        sys_rst <= 0;
        bus(1, REG_IRQ_EN, 1);
        foreach (rows[i]) begin
            op(rows[i].o, rows[i].a, rows[i].d);
            if (rows[i].c) chk(rq, 32'(rows[i].e));
        end
        chk(32'(irq), 1);
        bus(0, REG_STATUS, 0);
        chk(rq[2:1], 2'b10);
        bus(1, REG_IRQ_CLR, 3);
        bus(0, REG_IRQ_ST, 0);
        chk(32'({rq[1:0], irq}), 0);
        bus(0, 5'h02, 0);
        chk(rq, 0);
        bus(1, REG_IRQ_EN, 0);
        bl <= 200;
        op(OP_PROGRAM, 19'h40007, 16'h0101);
        bus(0, REG_STATUS, 0);
        chk(32'({rq[3], irq}), 32'h2);
        bus(0, REG_IRQ_ST, 0);
        chk(32'(rq[1]), 1);
        give_verdict();
    end
endmodule : test_fsc_ctrl
